// ### hdl/ucm_mode_ctrl.sv
// Mode decoder, measurement sequencer, annunciators and register port of the counter.
//
// Operation
// R1 - Frequency key, shift out: channel A frequency.
// R2 - Frequency key, shift in: channel A period.
// R3 - Interval key, shift out: A start to B stop.
// R4 - Interval key, shift in: averaged A-to-B intervals.
// R5 - Delayed interval: stop armed after gate-setting holdoff.
// R6 - Stop events ignored during holdoff, 500 us-30 ms.
// R7 - Check mode routes reference clock into counting_circuit.
// R8 - Ratio mode: channel A over channel B.
// R9 - Gated totalize counts A while B gate open.
// R10 - Third-input mode enables channel three, measures frequency.
// R11 - Gate display measures own gate, 60 ms-10 s.
// R12 - Trigger lights off in third-input or gate display.
// R13 - Trigger lights blink, off below, on above.
// R14 - Reset key clears display, count, remote.
// R15 - Gate light exactly while gate open; the code also lights it throughout the power-on self-check.
// R16 - Engineering exponent blank/3/6/9 with Hz or s.
// R17 - Exponent sign lamp on when exponent negative.
// R18 - Overflow lamp when digits exceed eight.
// R19 - Self-check fault lights error until cleared.
// R20 - Addressed and remote lamps follow bus state.
// R21 - No function key: display digit test sequence.
// R22 - First result withheld until gate time elapsed.
// R23 - Power-on self-check cycle lasts two seconds.
// R24 - Cycle: open, accumulate, close, latch, re-arm.
// R25 - Key change aborts and restarts the measurement.
//
// Added by the designer: the placing of the registers and strobed register access.
module ucm_mode_ctrl #(
	parameter int unsigned POWERUP_TK = ucm_pkg::POWERUP_TK,
	parameter int unsigned BLINK_TK = ucm_pkg::BLINK_TK,
	parameter int unsigned ACT_TK = ucm_pkg::ACT_TK,
	parameter int unsigned DTEST_TK = ucm_pkg::DTEST_TK
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [5:0] funcSw,
	input wire logic shiftKey,
	input wire logic separateInputs,
	input wire logic resetKey,
	input wire logic chanA,
	input wire logic chanB,
	input wire logic chanC,
	input wire logic refClk10,
	input wire logic selfTestFail,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output logic chanCEnable,
	output ucm_pkg::ucm_ind_s ind,
	output ucm_pkg::ucm_disp_s disp
);

	// ==========================================================================
	// Tick divider and input edges
	// ==========================================================================
	logic [5:0] div_q;
	logic aPrev_q, bPrev_q, cPrev_q, rPrev_q;
	wire tick = (div_q == ucm_pkg::TICK_LAST);
	wire riseA = chanA & ~aPrev_q;
	wire fallA = ~chanA & aPrev_q;
	wire riseB = chanB & ~bPrev_q;
	wire riseC = chanC & ~cPrev_q;
	wire riseRef = refClk10 & ~rPrev_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			div_q <= 6'h00;
			{aPrev_q, bPrev_q, cPrev_q, rPrev_q} <= 4'h0;
		end else begin
			div_q <= tick ? 6'h00 : div_q + 6'h01;
			{aPrev_q, bPrev_q, cPrev_q, rPrev_q} <= {chanA, chanB, chanC, refClk10};
		end
	end

	// ==========================================================================
	// Mode decode
	// ==========================================================================
	ucm_pkg::ucm_mode_e mode_q;
	ucm_pkg::ucm_state_e st_q, stD;
	logic [23:0] pwr_q, gateReg_q;
	wire powering = (pwr_q != 24'(POWERUP_TK)); // see R23
	wire ucm_pkg::ucm_mode_e modeD =
		funcSw[ucm_pkg::KEY_FREQ] ? (shiftKey ? ucm_pkg::PERIOD_CHAN_ONE : ucm_pkg::FREQ_CHAN_ONE) :
		funcSw[ucm_pkg::KEY_TI] ? (shiftKey ? ucm_pkg::INTERVAL_AVERAGE : ucm_pkg::INTERVAL) :
		funcSw[ucm_pkg::KEY_DLY] ? (shiftKey ? ucm_pkg::SELF_CHECK : ucm_pkg::INTERVAL_DELAYED) :
		funcSw[ucm_pkg::KEY_RATIO] ? (shiftKey ? ucm_pkg::GATED_TOTALIZE : ucm_pkg::RATIO) :
		funcSw[ucm_pkg::KEY_FREQC] ? (shiftKey ? ucm_pkg::GATE_DISPLAY : ucm_pkg::FREQ_CHAN_THREE) :
		funcSw[ucm_pkg::KEY_TOT] ? ucm_pkg::MANUAL_TOTALIZE : ucm_pkg::DISPLAY_TEST; // see R21
	wire modeChg = (modeD != mode_q);
	wire restart = !powering && (modeChg || resetKey); // see R25
	wire mFreq1 = (mode_q == ucm_pkg::FREQ_CHAN_ONE);
	wire mFreq3 = (mode_q == ucm_pkg::FREQ_CHAN_THREE);
	wire mCheck = (mode_q == ucm_pkg::SELF_CHECK);
	wire mGdisp = (mode_q == ucm_pkg::GATE_DISPLAY);
	wire mPer = (mode_q == ucm_pkg::PERIOD_CHAN_ONE);
	wire mTi = (mode_q == ucm_pkg::INTERVAL);
	wire mAvg = (mode_q == ucm_pkg::INTERVAL_AVERAGE);
	wire mDly = (mode_q == ucm_pkg::INTERVAL_DELAYED);
	wire mRatio = (mode_q == ucm_pkg::RATIO);
	wire mGtot = (mode_q == ucm_pkg::GATED_TOTALIZE);
	wire mTot = (mode_q == ucm_pkg::MANUAL_TOTALIZE);
	wire isTimed = mFreq1 | mFreq3 | mCheck | mGdisp | mAvg;
	wire isAccum = mGtot | mTot;
	wire isFreqKind = mFreq1 | mFreq3 | mCheck | mRatio;
	wire isTimeKind = mPer | mTi | mAvg | mDly | mGdisp;
	// In common-input wiring the stop edge is the falling edge of channel A.
	wire stopEv = separateInputs ? riseB : fallA; // see R3
	wire accGate = mGtot ? chanB : shiftKey; // see R9
	wire evtInc = (mFreq1 & riseA) | (mFreq3 & riseC) | (mCheck & riseRef) // see R1 R7
		| (isAccum & accGate & riseA) | (mRatio & riseA); // see R8
	// The single time knob is clamped to the range that the active mode allows.
	wire [23:0] gateTk = (gateReg_q < ucm_pkg::GATE_MIN_TK) ? ucm_pkg::GATE_MIN_TK :
		(gateReg_q > ucm_pkg::GATE_MAX_TK) ? ucm_pkg::GATE_MAX_TK : gateReg_q; // see R11
	wire [23:0] delayTk = (gateReg_q < ucm_pkg::DELAY_MIN_TK) ? ucm_pkg::DELAY_MIN_TK :
		(gateReg_q > ucm_pkg::DELAY_MAX_TK) ? ucm_pkg::DELAY_MAX_TK : gateReg_q; // see R6

	// ==========================================================================
	// Measurement sequencer
	// ==========================================================================
	logic [31:0] evt_q, ref_q, evtD, refD;
	logic [23:0] tmr_q, tmrD, hold_q;
	logic ivOpen_q, ivD, load, holdDone_q;

	always_comb begin
		stD = st_q;
		evtD = evt_q;
		refD = ref_q;
		tmrD = tick ? tmr_q + 24'h000001 : tmr_q;
		ivD = ivOpen_q;
		load = 1'b0;
		case (st_q)
			ucm_pkg::ST_POWER: begin
				if (!powering) begin
					stD = ucm_pkg::ST_ARM;
				end
			end
			ucm_pkg::ST_ARM: begin
				evtD = 32'h00000000;
				refD = 32'h00000000;
				tmrD = 24'h000000;
				ivD = 1'b0;
				if (isTimed || isAccum) begin
					stD = ucm_pkg::ST_OPEN;
				end else if ((mPer || mTi) && riseA) begin // see R3
					stD = ucm_pkg::ST_OPEN;
				end else if (mRatio && riseB) begin
					stD = ucm_pkg::ST_OPEN;
				end else if (mDly && riseA) begin
					stD = ucm_pkg::ST_HOLDOFF; // see R5
				end
			end
			ucm_pkg::ST_OPEN: begin
				if (isAccum) begin
					evtD = evt_q + {31'h00000000, evtInc};
				end else if (mAvg) begin // see R4
					refD = ref_q + {31'h00000000, ivOpen_q};
					if (!ivOpen_q && riseA) begin
						ivD = 1'b1;
					end else if (ivOpen_q && stopEv) begin
						ivD = 1'b0;
						evtD = evt_q + 32'h00000001;
						if (evt_q == ucm_pkg::AVG_LAST) begin
							stD = ucm_pkg::ST_DONE;
						end
					end
				end else if (mPer) begin // see R2
					refD = ref_q + 32'h00000001;
					if (riseA) begin
						stD = ucm_pkg::ST_DONE;
					end
				end else if (mTi || mDly) begin
					refD = ref_q + 32'h00000001;
					if (stopEv) begin
						stD = ucm_pkg::ST_DONE;
					end
				end else if (mRatio) begin
					evtD = evt_q + {31'h00000000, evtInc};
					if (riseB) begin
						stD = ucm_pkg::ST_DONE;
					end
				end else begin
					evtD = evt_q + {31'h00000000, evtInc};
					refD = ref_q + 32'h00000001;
					if (tmr_q >= gateTk) begin
						stD = ucm_pkg::ST_DONE;
					end
				end
			end
			ucm_pkg::ST_HOLDOFF: begin
				// Stop edges fall through unseen here; only the timer and the reference count move on.
				refD = ref_q + 32'h00000001;
				if (tmr_q >= delayTk) begin
					stD = ucm_pkg::ST_OPEN; // see R6
				end
			end
			ucm_pkg::ST_DONE: begin
				load = 1'b1;
				stD = ucm_pkg::ST_ARM; // see R24
			end
			default: begin
				stD = ucm_pkg::ST_ARM;
			end
		endcase
		if (restart) begin
			stD = ucm_pkg::ST_ARM;
			evtD = 32'h00000000;
			refD = 32'h00000000;
			tmrD = 24'h000000;
			ivD = 1'b0;
			load = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= ucm_pkg::ST_POWER;
			mode_q <= ucm_pkg::DISPLAY_TEST;
			{evt_q, ref_q} <= 64'h0;
			tmr_q <= 24'h000000;
			ivOpen_q <= 1'b0;
		end else begin
			st_q <= stD;
			mode_q <= modeD; // see R25
			{evt_q, ref_q} <= {evtD, refD};
			tmr_q <= tmrD;
			ivOpen_q <= ivD;
		end
	end

	// ==========================================================================
	// First-result holdoff, power-up timer, display test stepping
	// ==========================================================================
	logic [23:0] dtCnt_q;
	logic [3:0] dtDigit_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			pwr_q <= 24'h000000;
			hold_q <= 24'h000000;
			holdDone_q <= 1'b0;
			dtCnt_q <= 24'h000000;
			dtDigit_q <= 4'h0;
		end else begin
			if (powering && tick) begin
				pwr_q <= pwr_q + 24'h000001; // see R23
			end
			if (powering || restart) begin
				hold_q <= 24'h000000;
				holdDone_q <= 1'b0;
			end else if (tick && !holdDone_q) begin
				hold_q <= hold_q + 24'h000001;
				holdDone_q <= (hold_q >= gateTk); // see R22
			end
			if (mode_q != ucm_pkg::DISPLAY_TEST) begin
				dtCnt_q <= 24'h000000;
				dtDigit_q <= 4'h0;
			end else if (tick) begin
				dtCnt_q <= (dtCnt_q == 24'(DTEST_TK)) ? 24'h000000 : dtCnt_q + 24'h000001;
				if (dtCnt_q == 24'(DTEST_TK)) begin
					dtDigit_q <= (dtDigit_q == ucm_pkg::DIGIT_BLANK) ? 4'h0 : dtDigit_q + 4'h1;
				end
			end
		end
	end

	// ==========================================================================
	// Result latch and engineering format
	// ==========================================================================
	logic [31:0] dispVal_q;
	logic dispFreq_q, dispTime_q;
	wire [31:0] tBase = mAvg ? (ref_q >> ucm_pkg::AVG_SHIFT) : ref_q;
	// A count of 25 ns clocks becomes nanoseconds; the sum wraps past 4.29 s.
	wire [31:0] tNs = (tBase << 4) + (tBase << 3) + tBase;
	wire [31:0] result = isTimeKind ? tNs : evt_q;
	wire dispLoad = load && holdDone_q;
	wire big3 = (dispVal_q >= ucm_pkg::DEC_1E3);
	wire big6 = (dispVal_q >= ucm_pkg::DEC_1E6);
	wire overflow_indicator = (dispVal_q >= ucm_pkg::DEC_1E8); // see R18
	wire [1:0] expFreq = big6 ? 2'h2 : (big3 ? 2'h1 : 2'h0);
	wire [1:0] expTime = big6 ? 2'h1 : (big3 ? 2'h2 : 2'h3);
	wire [1:0] expMag = dispFreq_q ? expFreq : (dispTime_q ? expTime : 2'h0); // see R16

	always_ff @(posedge mclk) begin
		if (srst) begin
			dispVal_q <= 32'h00000000;
			{dispFreq_q, dispTime_q} <= 2'h0;
		end else if (restart) begin
			dispVal_q <= 32'h00000000; // see R14
			{dispFreq_q, dispTime_q} <= 2'h0;
		end else if (isAccum && st_q == ucm_pkg::ST_OPEN) begin
			dispVal_q <= evt_q;
			{dispFreq_q, dispTime_q} <= 2'h0;
		end else if (dispLoad) begin
			dispVal_q <= result;
			{dispFreq_q, dispTime_q} <= {isFreqKind, isTimeKind};
		end
	end

	// ==========================================================================
	// Trigger lights
	// ==========================================================================
	logic [23:0] blink_q;
	logic blinkPh_q;
	logic [1:0] lamp;
	wire [1:0] lvl = {chanB, chanA};
	wire [1:0] rise = {riseB, riseA};
	wire lampsOff = mFreq3 | mGdisp; // see R12

	always_ff @(posedge mclk) begin
		if (srst) begin
			blink_q <= 24'h000000;
			blinkPh_q <= 1'b0;
		end else if (tick) begin
			blink_q <= (blink_q == 24'(BLINK_TK)) ? 24'h000000 : blink_q + 24'h000001;
			blinkPh_q <= (blink_q == 24'(BLINK_TK)) ? ~blinkPh_q : blinkPh_q;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_trig
		logic [23:0] act_q;
		always_ff @(posedge mclk) begin
			if (srst) begin
				act_q <= 24'h000000;
			end else if (rise[i]) begin
				act_q <= 24'(ACT_TK);
			end else if (tick && act_q != 24'h000000) begin
				act_q <= act_q - 24'h000001;
			end
		end
		assign lamp[i] = (act_q != 24'h000000) ? blinkPh_q : lvl[i]; // see R13
	end

	// ==========================================================================
	// Register port and annunciators
	// ==========================================================================
	logic remote_q, addressed_q, err_q, chanCEn_q;
	ucm_pkg::ucm_ind_s ind_q, indD;
	ucm_pkg::ucm_disp_s disp_q;
	wire gateOpen = (st_q == ucm_pkg::ST_OPEN) || (st_q == ucm_pkg::ST_HOLDOFF);
	wire wrCtrl = regWr && (regAddr == ucm_pkg::REG_CTRL);
	wire wrGate = regWr && (regAddr == ucm_pkg::REG_GATE);
	wire errClr = wrCtrl && regWdata[ucm_pkg::CTRL_ERRCLR];
	wire [31:0] status = {23'h000000, chanCEn_q, overflow_indicator, err_q, powering, gateOpen, 4'(mode_q)};
	wire [31:0] rdMux =
		(regAddr == ucm_pkg::REG_CTRL) ? {30'h00000000, addressed_q, remote_q} :
		(regAddr == ucm_pkg::REG_GATE) ? {8'h00, gateReg_q} :
		(regAddr == ucm_pkg::REG_STATUS) ? status :
		(regAddr == ucm_pkg::REG_EVT) ? evt_q :
		(regAddr == ucm_pkg::REG_REF) ? ref_q :
		(regAddr == ucm_pkg::REG_DISP) ? dispVal_q : 32'h00000000;

	always_comb begin
		indD.trigA = powering | (lamp[0] & ~lampsOff);
		indD.trigB = powering | (lamp[1] & ~lampsOff);
		indD.gate = powering | gateOpen; // see R15
		indD.hz = powering | dispFreq_q;
		indD.sec = powering | dispTime_q;
		indD.overflowIndicator = powering | overflow_indicator;
		indD.expNeg = !powering && dispTime_q && (expMag != 2'h0); // see R17
		indD.expMag = powering ? 2'h0 : expMag;
		indD.error = err_q;
		indD.addressedIndicator = addressed_q; // see R20
		indD.remote = remote_q;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			remote_q <= 1'b0;
			addressed_q <= 1'b0;
			err_q <= 1'b0;
			chanCEn_q <= 1'b0;
			gateReg_q <= ucm_pkg::GATE_RST;
			regRdata <= 32'h00000000;
			ind_q <= '0;
			disp_q <= '0;
		end else begin
			if (resetKey && !powering) begin
				remote_q <= 1'b0; // see R14
			end else if (wrCtrl) begin
				remote_q <= regWdata[ucm_pkg::CTRL_REMOTE];
			end
			if (wrCtrl) begin
				addressed_q <= regWdata[ucm_pkg::CTRL_ADDR];
			end
			if (wrGate) begin
				gateReg_q <= regWdata[23:0];
			end
			if (powering && selfTestFail) begin
				err_q <= 1'b1; // see R19
			end else if (errClr) begin
				err_q <= 1'b0;
			end
			chanCEn_q <= mFreq3; // see R10
			regRdata <= regRd ? rdMux : 32'h00000000;
			ind_q <= indD;
			disp_q.value <= dispVal_q;
			disp_q.testMode <= (mode_q == ucm_pkg::DISPLAY_TEST);
			disp_q.testDigit <= dtDigit_q;
		end
	end

	assign ind = ind_q;
	assign disp = disp_q;
	assign chanCEnable = chanCEn_q;

	// ==========================================================================
	// Checks
	// ==========================================================================
	chk_error_sticky: assert property (@(posedge mclk) disable iff (srst) // see R19
		err_q && !errClr |=> err_q) else $error("error lamp dropped without clear");
	chk_trig_dark: assert property (@(posedge mclk) disable iff (srst) // see R12
		lampsOff && !powering |=> !ind.trigA && !ind.trigB)
		else $error("trigger light on in third-input or gate display");
	chk_gate_lamp: assert property (@(posedge mclk) disable iff (srst) // see R15
		!powering && !$past(powering) |-> ind.gate == $past(gateOpen))
		else $error("gate light disagrees with gate");
	chk_holdoff_stop: assert property (@(posedge mclk) disable iff (srst) // see R6
		st_q == ucm_pkg::ST_HOLDOFF && !restart |=> st_q != ucm_pkg::ST_DONE)
		else $error("stop accepted during holdoff");
	chk_holdoff_len: assert property (@(posedge mclk) disable iff (srst) // see R5
		$rose(st_q == ucm_pkg::ST_OPEN) && mDly |-> tmr_q >= delayTk)
		else $error("stop armed before holdoff ended");
	chk_restart_abort: assert property (@(posedge mclk) disable iff (srst) // see R25
		restart |=> st_q == ucm_pkg::ST_ARM && evt_q == 32'h00000000)
		else $error("measurement not restarted");
	chk_reset_key: assert property (@(posedge mclk) disable iff (srst) // see R14
		resetKey && !powering |=> !remote_q && dispVal_q == 32'h00000000)
		else $error("reset key did not clear");
	chk_first_hold: assert property (@(posedge mclk) disable iff (srst) // see R22
		load && !holdDone_q |=> $stable(dispVal_q) || isAccum)
		else $error("result shown before gate time elapsed");
	chk_overflow_indicator_lamp: assert property (@(posedge mclk) disable iff (srst) // see R18
		dispVal_q >= ucm_pkg::DEC_1E8 |=> ind.overflowIndicator)
		else $error("overflow lamp missing");
	chk_power_hold: assert property (@(posedge mclk) disable iff (srst) // see R23
		powering |-> st_q == ucm_pkg::ST_POWER) else $error("measuring during self-check");

endmodule : ucm_mode_ctrl

// ### hdl/ucm_pkg.sv
// Constants, types and the register map of the universal counter mode controller.
package ucm_pkg;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_NS = 25;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam logic [5:0] TICK_LAST = 6'(TICK_CYC - 1);
	localparam int DELAY_MIN_US = 500;
	localparam int DELAY_MAX_MS = 30;
	localparam int GATE_MIN_MS = 60;
	localparam int GATE_MAX_S = 10;
	localparam int POWERUP_S = 2;
	localparam int BLINK_MS = 100;
	localparam int ACT_MS = 200;
	localparam int DTEST_MS = 500;
	localparam logic [23:0] DELAY_MIN_TK = 24'((DELAY_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [23:0] DELAY_MAX_TK = 24'(DELAY_MAX_MS * (1000000 / TICK_NS));
	localparam logic [23:0] GATE_MIN_TK = 24'(GATE_MIN_MS * (1000000 / TICK_NS));
	localparam logic [23:0] GATE_MAX_TK = 24'(GATE_MAX_S * (1000000000 / TICK_NS));
	localparam int POWERUP_TK = POWERUP_S * (1000000000 / TICK_NS);
	localparam int BLINK_TK = BLINK_MS * (1000000 / TICK_NS);
	localparam int ACT_TK = ACT_MS * (1000000 / TICK_NS);
	localparam int DTEST_TK = DTEST_MS * (1000000 / TICK_NS);

	// ==========================================================================
	// Measurement and display constants
	// ==========================================================================
	localparam int AVG_SHIFT = 8;
	localparam logic [31:0] AVG_LAST = 32'h000000ff;
	localparam logic [31:0] DEC_1E3 = 32'h000003e8;
	localparam logic [31:0] DEC_1E6 = 32'h000f4240;
	localparam logic [31:0] DEC_1E8 = 32'h05f5e100;
	localparam logic [3:0] DIGIT_BLANK = 4'ha;
	localparam int KEY_FREQ = 0;
	localparam int KEY_TI = 1;
	localparam int KEY_DLY = 2;
	localparam int KEY_RATIO = 3;
	localparam int KEY_FREQC = 4;
	localparam int KEY_TOT = 5;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GATE = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_EVT = 8'h0c;
	localparam logic [7:0] REG_REF = 8'h10;
	localparam logic [7:0] REG_DISP = 8'h14;
	localparam int CTRL_REMOTE = 0;
	localparam int CTRL_ADDR = 1;
	localparam int CTRL_ERRCLR = 2;
	localparam logic [23:0] GATE_RST = 24'h0186a0;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [3:0] {
		DISPLAY_TEST, FREQ_CHAN_ONE, PERIOD_CHAN_ONE, INTERVAL, INTERVAL_AVERAGE,
		INTERVAL_DELAYED, SELF_CHECK, RATIO, GATED_TOTALIZE, FREQ_CHAN_THREE,
		GATE_DISPLAY, MANUAL_TOTALIZE
	} ucm_mode_e;

	typedef enum logic [2:0] {ST_POWER, ST_ARM, ST_OPEN, ST_HOLDOFF, ST_DONE} ucm_state_e;

	typedef struct packed {
		logic trigA;
		logic trigB;
		logic gate;
		logic hz;
		logic sec;
		logic overflowIndicator;
		logic expNeg;
		logic [1:0] expMag;
		logic error;
		logic addressedIndicator;
		logic remote;
	} ucm_ind_s;

	typedef struct packed {
		logic [31:0] value;
		logic [3:0] testDigit;
		logic testMode;
	} ucm_disp_s;

endpackage : ucm_pkg

// ### verif/test_universal_counter_mode_control.sv
// Self-checking bench of the counter mode controller.
module test_universal_counter_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, srst = 1'b1, shiftKey = 1'b0, separateInputs = 1'b1, resetKey = 1'b0;
	logic selfTestFail = 1'b1, regWr = 1'b0, regRd = 1'b0, chanA, chanB, chanC, refClk10;
	logic [5:0] funcSw = 6'h01;
	logic [2:0] hold = 3'h0, run = 3'h0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, rd;
	logic chanCEnable;
	ucm_pkg::ucm_ind_s ind;
	ucm_pkg::ucm_disp_s disp;
	int fails = 0, samplesChecked = 0, n;
	logic [5:0] swTab [12] = '{6'h00, 6'h01, 6'h01, 6'h02, 6'h02, 6'h04, 6'h04, 6'h08, 6'h08,
		6'h10, 6'h10, 6'h20};
	logic [11:0] shTab = 12'b010101010100;
	ucm_pkg::ucm_mode_e modeTab [12] = '{ucm_pkg::DISPLAY_TEST, ucm_pkg::FREQ_CHAN_ONE,
		ucm_pkg::PERIOD_CHAN_ONE, ucm_pkg::INTERVAL, ucm_pkg::INTERVAL_AVERAGE,
		ucm_pkg::INTERVAL_DELAYED, ucm_pkg::SELF_CHECK, ucm_pkg::RATIO, ucm_pkg::GATED_TOTALIZE,
		ucm_pkg::FREQ_CHAN_THREE, ucm_pkg::GATE_DISPLAY, ucm_pkg::MANUAL_TOTALIZE};

	ucm_mode_ctrl #(.POWERUP_TK(20), .BLINK_TK(4), .ACT_TK(8), .DTEST_TK(4)) uut (
		.mclk(mclk), .srst(srst), .funcSw(funcSw), .shiftKey(shiftKey),
		.separateInputs(separateInputs), .resetKey(resetKey), .chanA(chanA), .chanB(chanB),
		.chanC(chanC), .refClk10(refClk10), .selfTestFail(selfTestFail), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.chanCEnable(chanCEnable), .ind(ind), .disp(disp));
	ucm_front_model front (.mclk(mclk), .hold(hold), .run(run), .chanA(chanA), .chanB(chanB),
		.chanC(chanC), .refClk10(refClk10));

	// ==========================================================================
	// Helpers
	// ==========================================================================
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic waitc(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask : waitc
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : regWrite
	task automatic regRead(input logic [7:0] a);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask : regRead
	task automatic setKeys(input logic [5:0] sw, input logic sh);
		@(posedge mclk);
		funcSw <= sw;
		shiftKey <= sh;
	endtask : setKeys
	task automatic summarize;
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic testPowerUp;
		regRead(ucm_pkg::REG_STATUS);
		chk(rd[5], 1'b1);
		chk(ind.error, 1'b1);
		chk({ind.gate, ind.hz, ind.sec, ind.overflowIndicator}, 4'hf);
		regRead(ucm_pkg::REG_GATE);
		chk(rd, 32'h000186a0);
		selfTestFail <= 1'b0;
		waitc(900);
		regRead(ucm_pkg::REG_STATUS);
		chk(rd[6:5], 2'h2);
		regWrite(ucm_pkg::REG_CTRL, 32'h4);
		waitc(2);
		chk(ind.error, 1'b0);
		$display("test powerUp done");
	endtask : testPowerUp
	task automatic testRegs;
		regWrite(ucm_pkg::REG_CTRL, 32'h3);
		waitc(2);
		chk({ind.addressedIndicator, ind.remote}, 2'h3);
		regRead(8'h40);
		chk(rd, 32'h0);
		@(posedge mclk);
		resetKey <= 1'b1;
		@(posedge mclk);
		resetKey <= 1'b0;
		waitc(3);
		chk(ind.remote, 1'b0);
		$display("test regs done");
	endtask : testRegs
	task automatic testModes;
		for (int i = 0; i < 12; i++) begin
			setKeys(swTab[i], shTab[i]);
			waitc(4);
			regRead(ucm_pkg::REG_STATUS);
			chk(rd[3:0], modeTab[i]);
			chk(chanCEnable, modeTab[i] == ucm_pkg::FREQ_CHAN_THREE);
		end
		$display("test modes done");
	endtask : testModes
	task automatic testLamps;
		setKeys(6'h01, 1'b0);
		hold <= 3'h1;
		waitc(500);
		chk({ind.trigA, ind.trigB}, 2'h2);
		run <= 3'h1;
		n = 0;
		for (int i = 0; i < 400; i++) begin
			waitc(1);
			n += int'(ind.trigA);
		end
		chk(n > 0 && n < 400, 1'b1);
		run <= 3'h0;
		for (int i = 0; i < 2; i++) begin
			setKeys(6'h10, i[0]);
			waitc(3);
			chk({ind.trigA, ind.trigB}, 2'h0);
		end
		$display("test lamps done");
	endtask : testLamps
	task automatic testGate;
		setKeys(6'h01, 1'b1);
		hold <= 3'h0;
		waitc(4);
		hold <= 3'h1;
		waitc(3);
		chk(ind.gate, 1'b1);
		hold <= 3'h0;
		waitc(3);
		hold <= 3'h1;
		waitc(5);
		chk(ind.gate, 1'b0);
		@(posedge mclk);
		hold <= 3'h0;
		waitc(3);
		hold <= 3'h1;
		waitc(3);
		chk(ind.gate, 1'b1);
		setKeys(6'h02, 1'b0);
		waitc(4);
		chk(ind.gate, 1'b0);
		hold <= 3'h0;
		waitc(3);
		hold <= 3'h1;
		waitc(3);
		chk(ind.gate, 1'b1);
		hold <= 3'h0;
		waitc(3);
		chk(ind.gate, 1'b1);
		hold <= 3'h2;
		waitc(3);
		chk(ind.gate, 1'b0);
		separateInputs <= 1'b0;
		hold <= 3'h1;
		waitc(3);
		chk(ind.gate, 1'b1);
		hold <= 3'h0;
		waitc(3);
		chk(ind.gate, 1'b0);
		separateInputs <= 1'b1;
		$display("test gate done");
	endtask : testGate
	task automatic testCount(input logic [5:0] sw, input logic sh, input logic [2:0] src,
			input logic [31:0] exp);
		setKeys(sw, sh);
		run <= src;
		waitc(4);
		regRead(ucm_pkg::REG_EVT);
		n = rd;
		waitc(38);
		regRead(ucm_pkg::REG_EVT);
		chk(rd - n, exp);
		run <= 3'h0;
		$display("test count done");
	endtask : testCount
	task automatic testDelay;
		regWrite(ucm_pkg::REG_GATE, 32'h0);
		setKeys(6'h04, 1'b0);
		waitc(3);
		hold <= 3'h1;
		waitc(3);
		hold <= 3'h3;
		waitc(10000);
		chk(ind.gate, 1'b1);
		hold <= 3'h1;
		waitc(10100);
		chk(ind.gate, 1'b1);
		hold <= 3'h3;
		waitc(3);
		chk(ind.gate, 1'b0);
		$display("test delay done");
	endtask : testDelay
	task automatic testTotal;
		setKeys(6'h08, 1'b1);
		hold <= 3'h2;
		waitc(4);
		for (int i = 0; i < 8; i++) begin
			hold <= {1'b0, i < 5, 1'b1};
			waitc(2);
			hold <= {1'b0, i < 5, 1'b0};
			waitc(2);
		end
		chk(disp.value, 32'h5);
		chk({ind.hz, ind.sec, ind.expNeg, ind.expMag, ind.overflowIndicator}, 6'h00);
		regRead(ucm_pkg::REG_DISP);
		chk(rd, 32'h5);
		@(posedge mclk);
		resetKey <= 1'b1;
		@(posedge mclk);
		resetKey <= 1'b0;
		waitc(3);
		chk(disp.value, 32'h0);
		$display("test total done");
	endtask : testTotal
	task automatic testDisplay;
		setKeys(6'h00, 1'b0);
		waitc(5);
		chk({disp.testMode, disp.testDigit}, 5'h10);
		waitc(200);
		chk({disp.testMode, disp.testDigit}, 5'h11);
		$display("test display done");
	endtask : testDisplay

	// ==========================================================================
	// Sequence and watchdog
	// ==========================================================================
	initial begin
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		testPowerUp();
		testRegs();
		testModes();
		testLamps();
		testCount(6'h01, 1'b0, 3'h1, 32'h5);
		testCount(6'h04, 1'b1, 3'h0, 32'ha);
		testCount(6'h10, 1'b0, 3'h4, 32'h5);
		testGate();
		testDelay();
		testTotal();
		testDisplay();
		summarize();
	end
	// The whole run needs about 23000 clocks; this allows about twice that.
	initial begin
		#(50000 * 25);
		fails++;
		summarize();
	end
endmodule : test_universal_counter_mode_control

// ### verif/ucm_front_model.sv
// Front panel stand-in: conditioned channel levels and the 10 MHz reference level.
module ucm_front_model (
	input wire logic mclk,
	input wire logic [2:0] hold,
	input wire logic [2:0] run,
	output logic chanA,
	output logic chanB,
	output logic chanC,
	output logic refClk10
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] divQ = 2'h0;
	logic [2:0] togQ = 3'h0;
	// ==========================================================================
	// Sources
	// ==========================================================================
	// A running channel flips every four clocks, slow enough for the edge detector.
	always @(posedge mclk) begin
		divQ <= divQ + 2'h1;
		if (divQ == 2'h3) begin
			togQ <= ~togQ;
		end
	end
	assign refClk10 = divQ[1];
	assign chanA = run[0] ? togQ[0] : hold[0];
	assign chanB = run[1] ? togQ[1] : hold[1];
	assign chanC = run[2] ? togQ[2] : hold[2];
endmodule : ucm_front_model
